//--- src/ssg_pkg.sv
// Constants shared by the stop group output control block.
// Assumes a 100 MHz system clock and a 16-bit register port.
package ssg_pkg;
	// ---------------------------------------------------------------
	// Register port geometry and map (word indices)
	// ---------------------------------------------------------------
	localparam int          DATA_W        = 16;
	localparam int          ADDR_W        = 4;
	localparam logic [3:0]  ADDR_CMD      = 4'h0;
	localparam logic [3:0]  ADDR_STATUS   = 4'h1;
	localparam logic [3:0]  ADDR_CFG      = 4'h2;
	localparam logic [3:0]  ADDR_HOST_OUT = 4'h3;

	// ---------------------------------------------------------------
	// Command register values
	// ---------------------------------------------------------------
	localparam logic [15:0] CMD_NONE      = 16'h0000;
	localparam logic [15:0] CMD_STOP      = 16'h0001;
	localparam logic [15:0] CMD_START     = 16'h0002;

	// ---------------------------------------------------------------
	// Status register bit positions
	// ---------------------------------------------------------------
	localparam int          ST_PEER_BTN   = 5;
	localparam int          ST_NET_LOSS   = 6;
	localparam int          ST_HOST_LOSS  = 7;
	localparam int          ST_BTN_LEFT   = 8;
	localparam int          ST_BTN_RIGHT  = 9;
	localparam int          ST_HOST_STOP  = 10;

	// ---------------------------------------------------------------
	// Configuration register fields
	// ---------------------------------------------------------------
	localparam int          CFG_REMOTE_IO = 0;
	localparam int          CFG_STOP_BTN  = 1;  // Bits 2:1, one per port
	localparam int          CFG_START_BTN = 3;  // Bits 4:3, one per port
	localparam int          CFG_PORT_REM  = 5;
	localparam int          CFG_POLICY    = 6;  // 1 = all off on stop
	localparam int          CFG_MOTOR_DIO = 7;  // Bits 8:7, one per port
	localparam logic [15:0] CFG_RESET     = 16'h0000;

	// Host output request register fields
	localparam int          HO_CTRL       = 0;  // Bits 1:0
	localparam int          HO_MOTOR      = 2;  // Bits 3:2
	localparam logic [15:0] HO_RESET      = 16'h0000;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          MS_NS         = 1000000;
	localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam int          HOST_GAP_MS   = 100;
	// Holding register index where assembly instances begin
	localparam logic [15:0] ASM_BASE      = 16'd1000;

	// Group state, gray along run <-> stop
	typedef enum logic {
		SSG_RUN  = 1'b0,
		SSG_STOP = 1'b1
	} ssg_state_t;
endpackage

//--- src/ssg_stop_group.sv
// Stop group output control: group stop latch, start acceptance, output
// gating for control ports, motor digital ports and relay-fed outputs.
// Assumes buttons and peer lines are pins; network status is on clk.
// Function
// - Zone mode, no stop or start button: port output follows zone blocked status.
// - Port with stop button energizes output while stopped, else off.
// - Remote mode or remote port control: stop applies host-loss policy.
// - Motor digital outputs during stop follow only host-loss policy.
// - Stop drops the relay feeding the four relay-fed outputs.
// - First two outputs ignore stop and follow program logic.
// - Upstream neighbour told to refuse infeed while group is stopped.
// - Start accepted only when powered, buttons reset, links present.
// - Host start to one module is passed on to the whole group.
// - Port with start button energizes when started, off when stopped.
// - Command and status registers are each 16 bits wide.
// - Once seen, loss of any assembly connection stops the group.
// - Assembly register traffic absent over 100 ms raises a stop.
// - Traffic to low holding registers is never watched for loss.
// - Any established cyclic I/O connection lost stops the group.
// - Command value 1 stops, value 2 starts.
// - Status bits 6, 7, 10 flag net, host, host-stop; zero means clear.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ssg_stop_group #(
	parameter int NCONN     = 4,
	parameter int MS_CYC    = ssg_pkg::MS_CYCLES,
	parameter int GAP_MS    = ssg_pkg::HOST_GAP_MS
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic [ssg_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [ssg_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [ssg_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic [1:0]                 stop_btn,
	input  wire logic [1:0]                 start_btn,
	input  wire logic                       peer_stop_in,
	input  wire logic                       peer_start_in,
	input  wire logic                       group_powered,
	input  wire logic                       peer_link_ok,
	input  wire logic [NCONN-1:0]           asm_conn_up,
	input  wire logic [NCONN-1:0]           cyc_conn_up,
	input  wire logic                       mb_req,
	input  wire logic [15:0]                mb_addr,
	input  wire logic [1:0]                 zone_blocked,
	input  wire logic [5:0]                 prog_out,
	output logic      [1:0]                 ctrl_out,
	output logic      [1:0]                 motor_out,
	output logic      [5:0]                 io_out,
	output logic                            relay_on,
	output logic                            upstream_refuse,
	output logic                            group_stop_out,
	output logic                            group_start_out
);
	import ssg_pkg::*;

	// Apply the host-loss policy to a requested output during a stop
	function automatic logic [1:0] policy_gate(input logic stopped,
		input logic all_off, input logic [1:0] req);
		policy_gate = (stopped && all_off) ? 2'h0 : req;
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [7:0] s1_ff, s2_ff, s3_ff;
	logic [7:0] pins;
	assign pins = {peer_link_ok, group_powered, peer_start_in,
		peer_stop_in, start_btn, stop_btn};
	// Only s2 and later are read; s3 gives edge detection of starts
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{s3_ff, s2_ff, s1_ff} <= 24'h000000;
		end else begin
			{s3_ff, s2_ff, s1_ff} <= {s2_ff, s1_ff, pins};
		end
	end
	logic [1:0] btn_stop_s;
	logic       peer_stop_s, powered_s, link_s;
	logic       btn_start_rise, peer_start_rise;
	assign btn_stop_s      = s2_ff[1:0];
	assign peer_stop_s     = s2_ff[4];
	assign powered_s       = s2_ff[6];
	assign link_s          = s2_ff[7];
	assign btn_start_rise  = |(s2_ff[3:2] & ~s3_ff[3:2]);
	assign peer_start_rise = s2_ff[5] & ~s3_ff[5];

	// ---------------------------------------------------------------
	// Registers reached over the plain port
	// ---------------------------------------------------------------
	logic [15:0] cmd_ff, cfg_ff, host_ff, rdata_ff;
	logic [15:0] nxt_cmd, nxt_cfg, nxt_host, nxt_rdata, status;
	logic        host_start_pulse;
	always_comb begin
		nxt_cmd   = cmd_ff;
		nxt_cfg   = cfg_ff;
		nxt_host  = host_ff;
		nxt_rdata = 16'h0000;
		if (reg_wr && reg_addr == ADDR_CMD) begin
			nxt_cmd = reg_wdata;
		end else if (reg_wr && reg_addr == ADDR_CFG) begin
			nxt_cfg = reg_wdata;
		end else if (reg_wr && reg_addr == ADDR_HOST_OUT) begin
			nxt_host = reg_wdata;
		end
		if (reg_rd && reg_addr == ADDR_CMD) begin
			nxt_rdata = cmd_ff;
		end else if (reg_rd && reg_addr == ADDR_STATUS) begin
			nxt_rdata = status;
		end else if (reg_rd && reg_addr == ADDR_CFG) begin
			nxt_rdata = cfg_ff;
		end else if (reg_rd && reg_addr == ADDR_HOST_OUT) begin
			nxt_rdata = host_ff;
		end
	end
	// Writing the start value is the host start event
	assign host_start_pulse = reg_wr && reg_addr == ADDR_CMD &&
		reg_wdata == CMD_START;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_ff   <= CMD_NONE;
			cfg_ff   <= CFG_RESET;
			host_ff  <= HO_RESET;
			rdata_ff <= 16'h0000;
		end else begin
			cmd_ff   <= nxt_cmd;
			cfg_ff   <= nxt_cfg;
			host_ff  <= nxt_host;
			rdata_ff <= nxt_rdata;
		end
	end
	assign reg_rdata = rdata_ff;
	// ---------------------------------------------------------------
	// Connection supervision
	// ---------------------------------------------------------------
	logic [NCONN-1:0] asm_seen_ff, cyc_seen_ff, nxt_asm_seen, nxt_cyc_seen;
	logic [31:0]      div_ff, nxt_div;
	logic [31:0]      gap_ff, nxt_gap;
	logic             mb_armed_ff, nxt_mb_armed, ms_tick, mb_hit, mb_loss;
	assign ms_tick = (div_ff == 32'(MS_CYC - 1));
	// Only requests into the assembly area keep the watchdog fed
	// Low holding register traffic is not watched
	assign mb_hit  = mb_req && (mb_addr >= ASM_BASE);
	always_comb begin
		// A connection once seen is expected from then on
		nxt_asm_seen = asm_seen_ff | asm_conn_up;
		nxt_cyc_seen = cyc_seen_ff | cyc_conn_up;
		nxt_div      = ms_tick ? 32'h0 : div_ff + 32'h1;
		nxt_mb_armed = mb_armed_ff | mb_hit;
		nxt_gap      = gap_ff;
		if (mb_hit) begin
			nxt_gap = 32'h0;
		end else if (ms_tick && mb_armed_ff && !mb_loss) begin
			nxt_gap = gap_ff + 32'h1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			asm_seen_ff <= '0;
			cyc_seen_ff <= '0;
			div_ff      <= 32'h0;
			gap_ff      <= 32'h0;
			mb_armed_ff <= 1'b0;
		end else begin
			asm_seen_ff <= nxt_asm_seen;
			cyc_seen_ff <= nxt_cyc_seen;
			div_ff      <= nxt_div;
			gap_ff      <= nxt_gap;
			mb_armed_ff <= nxt_mb_armed;
		end
	end
	// Loss once more than the gap has passed without a request
	assign mb_loss = mb_armed_ff && (gap_ff > 32'(GAP_MS));
	// ---------------------------------------------------------------
	// Live stop sources and status
	// ---------------------------------------------------------------
	logic host_loss, net_loss, local_src, any_src, criteria_ok;
	// Message traffic has no input here, so it cannot cause a stop
	assign host_loss = (|(asm_seen_ff & ~asm_conn_up)) |
		(|(cyc_seen_ff & ~cyc_conn_up)) | mb_loss;
	assign net_loss  = ~link_s;
	// Live source bits, all zero when nothing holds the group
	always_comb begin
		status               = 16'h0000;
		status[ST_PEER_BTN]  = peer_stop_s;
		status[ST_NET_LOSS]  = net_loss;
		status[ST_HOST_LOSS] = host_loss;
		status[ST_BTN_LEFT]  = btn_stop_s[0];
		status[ST_BTN_RIGHT] = btn_stop_s[1];
		// Value 1 issues a stop from the host
		status[ST_HOST_STOP] = (cmd_ff == CMD_STOP);
	end
	assign local_src   = net_loss | host_loss | (|btn_stop_s) |
		(cmd_ff == CMD_STOP);
	assign any_src     = local_src | peer_stop_s;
	assign criteria_ok = powered_s && !any_src;
	// ---------------------------------------------------------------
	// Group state; stop from any source wins over a start
	// ---------------------------------------------------------------
	ssg_state_t state_ff, nxt_state;
	logic       start_req, start_ok, nxt_start_out, start_out_ff;
	assign start_req = btn_start_rise | peer_start_rise | host_start_pulse;
	assign start_ok  = start_req && criteria_ok;
	always_comb begin
		nxt_state     = state_ff;
		nxt_start_out = 1'b0;
		case (state_ff)
			SSG_RUN: begin
				if (any_src) begin
					nxt_state = SSG_STOP;
				end
			end
			SSG_STOP: begin
				// Leave stop only on an accepted start
				if (start_ok) begin
					nxt_state     = SSG_RUN;
					// Pass the start on to every peer
					nxt_start_out = 1'b1;
				end
			end
			default: nxt_state = SSG_STOP;
		endcase
	end
	// Powers up stopped so a fresh group needs an explicit start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff     <= SSG_STOP;
			start_out_ff <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			start_out_ff <= nxt_start_out;
		end
	end
	logic stopped;
	assign stopped         = (state_ff == SSG_STOP);
	// Local sources are sent to the peers as a level
	assign group_stop_out  = local_src;
	assign group_start_out = start_out_ff;
	// ---------------------------------------------------------------
	// Output gating, registered
	// ---------------------------------------------------------------
	logic [1:0] ctrl_ff, motor_ff, nxt_ctrl, nxt_motor, ctrl_pol;
	logic [5:0] io_ff, nxt_io;
	logic       relay_ff, refuse_ff, nxt_relay, nxt_refuse, port_rem;
	assign port_rem = cfg_ff[CFG_REMOTE_IO] | cfg_ff[CFG_PORT_REM];
	assign ctrl_pol = policy_gate(stopped, cfg_ff[CFG_POLICY],
		host_ff[HO_CTRL+:2]);
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			if (cfg_ff[CFG_STOP_BTN+p]) begin
				nxt_ctrl[p] = stopped;
			end else if (cfg_ff[CFG_START_BTN+p]) begin
				nxt_ctrl[p] = !stopped;
			end else if (port_rem) begin
				nxt_ctrl[p] = ctrl_pol[p];
			end else begin
				// Zone status, stop has no effect
				nxt_ctrl[p] = zone_blocked[p];
			end
		end
		// Motor digital ports only see the policy
		nxt_motor  = policy_gate(stopped, cfg_ff[CFG_POLICY],
			host_ff[HO_MOTOR+:2]) & cfg_ff[CFG_MOTOR_DIO+:2];
		// Relay drops on stop, whatever the program asks
		nxt_relay  = !stopped;
		nxt_io     = {prog_out[5:2] & {4{!stopped}}, prog_out[1:0]};
		// Refuse infeed from upstream while stopped
		nxt_refuse = stopped;
	end
	// Outputs registered together; infeed refusal powers up asserted
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{ctrl_ff, motor_ff, io_ff, relay_ff, refuse_ff} <= 12'h001;
		end else begin
			{ctrl_ff, motor_ff, io_ff, relay_ff, refuse_ff} <=
				{nxt_ctrl, nxt_motor, nxt_io, nxt_relay, nxt_refuse};
		end
	end
	assign ctrl_out        = ctrl_ff;
	assign motor_out       = motor_ff;
	assign io_out          = io_ff;
	assign relay_on        = relay_ff;
	assign upstream_refuse = refuse_ff;
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_stop_write;
		reg_wr && reg_addr == ADDR_CMD && reg_wdata == CMD_STOP;
	endsequence
	sequence s_stopped_out;
		stopped ##1 (relay_on == 1'b0 && io_out[5:2] == 4'h0);
	endsequence
	a_zone_follow: assert property (
		!cfg_ff[CFG_STOP_BTN] && !cfg_ff[CFG_START_BTN] && !port_rem
		|=> ctrl_out[0] == $past(zone_blocked[0]))
		else $error("control port did not follow zone status");
	a_stop_lamp: assert property (
		cfg_ff[CFG_STOP_BTN+1] |=> ctrl_out[1] == $past(stopped))
		else $error("stop lamp does not match group state");
	a_relay_drop: assert property (
		s_stop_write ##1 1'b1 |-> ##1 s_stopped_out)
		else $error("relay-fed outputs alive after stop command");
	a_unswitched_io: assert property (
		1'b1 |=> io_out[1:0] == $past(prog_out[1:0]))
		else $error("unswitched outputs disturbed");
	a_infeed_refuse: assert property (
		stopped |=> upstream_refuse)
		else $error("upstream not refused on stop");
	a_start_gate: assert property (
		$fell(stopped) |-> $past(powered_s && !any_src && start_req))
		else $error("start accepted without criteria");
	a_start_spread: assert property (
		$fell(stopped) |-> group_start_out ##1 !group_start_out)
		else $error("start not passed on as one pulse");
	a_conn_loss: assert property (
		!stopped && (|(asm_seen_ff & ~asm_conn_up)) |=> stopped)
		else $error("assembly loss did not stop group");
	a_host_stop_bit: assert property (
		s_stop_write |=> status[ST_HOST_STOP] ##1 stopped)
		else $error("host stop not flagged");
endmodule
`default_nettype wire

//--- tb/ssg_peer_model.sv
// Model of the host and of the peer modules around one stop group module.
// Assumes the bench steers it with plain levels on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ssg_peer_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        mb_en,
	input  wire logic        mb_high,
	input  wire logic        kick,
	input  wire logic        hold,
	input  wire logic        link_up,
	input  wire logic        pwr_up,
	output logic             mb_req,
	output logic [15:0]      mb_addr,
	output logic             peer_stop_in,
	output logic             peer_start_in,
	output logic             group_powered,
	output logic             peer_link_ok
);
	import ssg_pkg::*;
	logic [3:0] gap_ff;
	logic       due;
	assign due = mb_en && (gap_ff == 4'h9);
	// Host polls every ten cycles, well inside the loss window
	// request spacing, high or low range
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap_ff <= 4'h0;
			mb_req <= 1'b0;
			mb_addr <= 16'h0000;
		end else begin
			gap_ff <= (gap_ff == 4'h9) ? 4'h0 : gap_ff + 4'h1;
			mb_req <= due;
			// Idle address lines wander so nothing relies on a held value
			mb_addr <= due ? (mb_high ? ASM_BASE : 16'd999) : ~mb_addr;
		end
	end
	// Peer pins follow the bench's levels
	// power, links, peer start and stop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			peer_stop_in <= 1'b0;
			peer_start_in <= 1'b0;
			group_powered <= 1'b0;
			peer_link_ok <= 1'b0;
		end else begin
			peer_stop_in <= hold;
			peer_start_in <= kick;
			group_powered <= pwr_up;
			peer_link_ok <= link_up;
		end
	end
endmodule
`default_nettype wire

//--- tb/test_ssg_stop_group.sv
// Self-checking bench for the stop group output control block.
// Assumes the peer model supplies group pins and Modbus traffic.
`timescale 1ns/1ps
`default_nettype none
module test_ssg_stop_group;
	import ssg_pkg::*;
	localparam int NC = 4;
	logic          clk, rst, reg_wr, reg_rd, mb_req, peer_stop_in;
	logic [3:0]    reg_addr;
	logic [15:0]   reg_wdata, reg_rdata, mb_addr, st;
	logic [1:0]    stop_btn, start_btn, zone_blocked, ctrl_out, motor_out;
	logic [NC-1:0] asm_conn_up, cyc_conn_up;
	logic [5:0]    prog_out, io_out;
	logic          peer_start_in, group_powered, peer_link_ok, relay_on;
	logic          upstream_refuse, group_stop_out, group_start_out;
	logic          mb_en, mb_high, kick, hold, link_up, pwr_up;
	int            miscompares, comparisons;
	logic [15:0]   cfg_tab [7];
	logic [3:0]    exp_tab [7];
	logic [3:0]    msk_tab [7];

	ssg_stop_group #(.NCONN(NC), .MS_CYC(10), .GAP_MS(3)) i_ssg_stop_group (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.stop_btn(stop_btn), .start_btn(start_btn),
		.peer_stop_in(peer_stop_in), .peer_start_in(peer_start_in),
		.group_powered(group_powered), .peer_link_ok(peer_link_ok),
		.asm_conn_up(asm_conn_up), .cyc_conn_up(cyc_conn_up),
		.mb_req(mb_req), .mb_addr(mb_addr), .zone_blocked(zone_blocked),
		.prog_out(prog_out), .ctrl_out(ctrl_out), .motor_out(motor_out),
		.io_out(io_out), .relay_on(relay_on),
		.upstream_refuse(upstream_refuse), .group_stop_out(group_stop_out),
		.group_start_out(group_start_out));
	ssg_peer_model i_ssg_peer_model (
		.clk(clk), .rst(rst), .mb_en(mb_en), .mb_high(mb_high), .kick(kick),
		.hold(hold), .link_up(link_up), .mb_req(mb_req), .mb_addr(mb_addr),
		.pwr_up(pwr_up),
		.peer_stop_in(peer_stop_in), .peer_start_in(peer_start_in),
		.group_powered(group_powered), .peer_link_ok(peer_link_ok));

	// Clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ---------------------------------------------------------------
	// Access and check tasks
	// ---------------------------------------------------------------
	task automatic wrap_up();
		if (miscompares == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Bounded wait for the one-cycle start pulse
	task automatic await_start();
		int k;
		k = 0;
		#1;
		while (group_start_out !== 1'b1) begin
			tick(1);
			k++;
			if (k > 20) begin
				chk("start pulse", 16'h0001, 16'h0000);
				wrap_up();
			end
		end
	endtask
	task automatic cmd_start();
		wr(ADDR_CMD, CMD_NONE);
		tick(2);
		rd(ADDR_STATUS, st);
		chk("status clear", 16'h0000, st);
		wr(ADDR_CMD, CMD_START);
		await_start();
		tick(3);
		chk("relay run", 16'h0001, 16'(relay_on));
		chk("refuse run", 16'h0000, 16'(upstream_refuse));
		chk("stop src run", 16'h0000, 16'(group_stop_out));
		wr(ADDR_CMD, CMD_NONE);
	endtask
	task automatic chk_stopped(input logic [15:0] bits);
		// Pin-borne stops need a model flop and two sync stages first
		tick(6);
		chk("relay stop", 16'h0000, 16'(relay_on));
		chk("refuse stop", 16'h0001, 16'(upstream_refuse));
		chk("io stop", 16'h0003, 16'(io_out));
		rd(ADDR_STATUS, st);
		chk("status bits", bits, st & bits);
	endtask
	task automatic conn_loss(input int sel);
		@(posedge clk);
		if (sel == 0) asm_conn_up <= 4'h1;
		else cyc_conn_up <= 4'h4;
		tick(4);
		chk("conn up", 16'h0001, 16'(relay_on));
		@(posedge clk);
		if (sel == 0) asm_conn_up <= 4'h0;
		else cyc_conn_up <= 4'h0;
		chk_stopped(16'h0080);
		@(posedge clk);
		if (sel == 0) asm_conn_up <= 4'h1;
		else cyc_conn_up <= 4'h4;
		cmd_start();
	endtask

	// Main sequence
	initial begin
		cfg_tab = '{16'h0000, 16'h0004, 16'h01c1, 16'h0181, 16'h0060,
			16'h0020, 16'h0003};
		exp_tab = '{4'h1, 4'h3, 4'h0, 4'he, 4'h0, 4'h2, 4'h3};
		msk_tab = '{4'h3, 4'h3, 4'hf, 4'hf, 4'h3, 4'h3, 4'h3};
		{reg_wr, reg_rd, mb_en, mb_high, kick, hold} = 6'h00;
		{reg_addr, reg_wdata, stop_btn, start_btn} = '0;
		{asm_conn_up, cyc_conn_up} = '0;
		zone_blocked = 2'b01;
		prog_out = 6'h3f;
		link_up = 1'b1;
		pwr_up = 1'b1;
		miscompares = 0;
		comparisons = 0;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		tick(6);
		chk("relay reset", 16'h0000, 16'(relay_on));
		chk("refuse reset", 16'h0001, 16'(upstream_refuse));
		rd(ADDR_CFG, st);
		chk("cfg reset", CFG_RESET, st);
		rd(ADDR_HOST_OUT, st);
		chk("host out reset", HO_RESET, st);
		wr(ADDR_STATUS, 16'hffff);
		rd(ADDR_STATUS, st);
		chk("status ro", 16'h0000, st);
		rd(4'h9, st);
		chk("unmapped", 16'h0000, st);
		wr(ADDR_CFG, 16'h0012);
		cmd_start();
		chk("ports run", 16'h0002, 16'(ctrl_out));
		wr(ADDR_CMD, CMD_STOP);
		chk_stopped(16'h0400);
		chk("ports stop", 16'h0001, 16'(ctrl_out));
		wr(ADDR_HOST_OUT, 16'h000e);
		for (int i = 0; i < 7; i++) begin
			wr(ADDR_CFG, cfg_tab[i]);
			tick(3);
			st = 16'({motor_out, ctrl_out} & msk_tab[i]);
			chk("ports", 16'(exp_tab[i]), st);
		end
		wr(ADDR_CFG, 16'h0010);
		@(posedge clk);
		stop_btn <= 2'b01;
		wr(ADDR_CMD, CMD_NONE);
		tick(6);
		rd(ADDR_STATUS, st);
		chk("button bit", 16'h0100, st & 16'h0100);
		@(posedge clk);
		start_btn <= 2'b10;
		tick(8);
		chk("start refused", 16'h0000, 16'(relay_on));
		@(posedge clk);
		start_btn <= 2'b00;
		stop_btn <= 2'b00;
		tick(6);
		@(posedge clk);
		start_btn <= 2'b10;
		await_start();
		@(posedge clk);
		start_btn <= 2'b00;
		tick(3);
		chk("button start", 16'h0001, 16'(relay_on));
		@(posedge clk);
		hold <= 1'b1;
		chk_stopped(16'h0020);
		@(posedge clk);
		hold <= 1'b0;
		tick(6);
		chk("stop latched", 16'h0000, 16'(relay_on));
		// A peer start while a module is unpowered must be refused
		@(posedge clk);
		pwr_up <= 1'b0;
		tick(6);
		@(posedge clk);
		kick <= 1'b1;
		tick(8);
		chk("start unpowered", 16'h0000, 16'(relay_on));
		@(posedge clk);
		kick <= 1'b0;
		pwr_up <= 1'b1;
		tick(6);
		@(posedge clk);
		kick <= 1'b1;
		await_start();
		@(posedge clk);
		kick <= 1'b0;
		conn_loss(0);
		conn_loss(1);
		@(posedge clk);
		mb_en <= 1'b1;
		tick(40);
		@(posedge clk);
		mb_en <= 1'b0;
		tick(60);
		chk("low range loss", 16'h0001, 16'(relay_on));
		@(posedge clk);
		mb_high <= 1'b1;
		mb_en <= 1'b1;
		tick(60);
		chk("polled", 16'h0001, 16'(relay_on));
		@(posedge clk);
		mb_en <= 1'b0;
		tick(60);
		chk_stopped(16'h0080);
		@(posedge clk);
		link_up <= 1'b0;
		tick(6);
		rd(ADDR_STATUS, st);
		chk("net loss bit", 16'h0040, st & 16'h0040);
		chk("stop source", 16'h0001, 16'(group_stop_out));
		wrap_up();
	end
endmodule
`default_nettype wire
